//--- common/deic_consts.svh
// constants for the diagnostic edge interrupt channel
`ifndef DEIC_CONSTS_SVH
`define DEIC_CONSTS_SVH
`define DEIC_CTRL_OFFSET   32'h4000_0204
`define DEIC_STAT_OFFSET   32'h4000_0208
`define DEIC_CLR_OFFSET    32'h4000_020C
`define DEIC_IEN_OFFSET    32'h4000_0210
`define DEIC_FLAG_BIT      7
`define DEIC_EDGE_BIT      6
`define DEIC_LANE_HI       5
`define DEIC_LANE_LO       3
`define DEIC_WSEL_HI       2
`define DEIC_WSEL_LO       1
`define DEIC_MASK_BIT      0
`define DEIC_CTRL_RESET    7'h00
`define DEIC_RD_UNMAPPED   32'h0000_0000
`endif

//--- common/deic_pkg.sv
// types for the diagnostic edge interrupt channel
package deic_pkg;
  typedef logic [31:0] deic_word_t;
  typedef logic [7:0]  deic_diag_t;
  typedef enum logic [1:0] {
    DEIC_SRC_LINK0  = 2'h0,
    DEIC_SRC_LINK1  = 2'h1,
    DEIC_SRC_RADIO0 = 2'h2,
    DEIC_SRC_RADIO1 = 2'h3
  } deic_src_t;
endpackage

//--- common/deic_sel_if.sv
// selection signals between channel core and edge detector
`timescale 1ns/10ps
interface deic_sel_if;
  import deic_pkg::*;
  deic_src_t  source_word_sel;
  logic [2:0] bit_lane_sel;
  logic       edge_polarity_sel;
  logic       edge_hit;
  modport ctrl (output source_word_sel, output bit_lane_sel, output edge_polarity_sel,
                input edge_hit);
  modport det  (input source_word_sel, input bit_lane_sel, input edge_polarity_sel,
                output edge_hit);
endinterface

//--- core/deic_edge_det.sv
// edge detector on one selected bit of four diagnostic words
`timescale 1ns/10ps
module deic_edge_det
  import deic_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire deic_diag_t link_diag_word0,
  input  wire deic_diag_t link_diag_word1,
  input  wire deic_diag_t radio_diag_word0,
  input  wire deic_diag_t radio_diag_word1,
  deic_sel_if.det    sel
);
  deic_diag_t word_sel;
  logic       bit_now;
  logic       bit_q;
  logic       bit_d;

  // word mux then lane index
  always_comb begin
    unique case (sel.source_word_sel)
      DEIC_SRC_LINK0:  word_sel = link_diag_word0;
      DEIC_SRC_LINK1:  word_sel = link_diag_word1;
      DEIC_SRC_RADIO0: word_sel = radio_diag_word0;
      DEIC_SRC_RADIO1: word_sel = radio_diag_word1;
    endcase
    bit_now = word_sel[sel.bit_lane_sel];
    bit_d   = bit_now;
  end

  // previous value of the selected bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end

  // rising for polarity 0, falling for polarity 1
  assign sel.edge_hit = sel.edge_polarity_sel ? (bit_q & ~bit_now)
                                              : (~bit_q & bit_now);
endmodule // deic_edge_det

//--- core/deic_channel.sv
// diagnostic edge interrupt channel with register port
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "deic_consts.svh"
module deic_channel
  import deic_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire deic_word_t addr,
  input  wire deic_word_t wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic [31:0]     rdata,
  input  wire deic_diag_t link_diag_word0,
  input  wire deic_diag_t link_diag_word1,
  input  wire deic_diag_t radio_diag_word0,
  input  wire deic_diag_t radio_diag_word1,
  output logic            diag_irq_line
);
  deic_sel_if sel ();

  logic [6:0]  cfg_q,  cfg_d;   // polarity, lane, word, enable
  logic        flag_q, flag_d;
  logic        stat_q, stat_d;  // sticky interrupt status
  logic        ien_q,  ien_d;
  logic [31:0] rdata_q, rdata_d;
  logic        irq_q,  irq_d;
  logic [31:0] diag_all;        // all four words from the pins, word 0 lowest
  logic        lane_ref;        // selected bit taken straight from the pins

  // address match helper
  function automatic logic hit(input deic_word_t a, input deic_word_t off);
    return a == off;
  endfunction

  assign sel.source_word_sel   = deic_src_t'(cfg_q[`DEIC_WSEL_HI:`DEIC_WSEL_LO]);
  assign sel.bit_lane_sel      = cfg_q[`DEIC_LANE_HI:`DEIC_LANE_LO];
  assign sel.edge_polarity_sel = cfg_q[`DEIC_EDGE_BIT];

  deic_edge_det u_det (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .link_diag_word0  (link_diag_word0),
    .link_diag_word1  (link_diag_word1),
    .radio_diag_word0 (radio_diag_word0),
    .radio_diag_word1 (radio_diag_word1),
    .sel              (sel)
  );

  // next state of registers, flags and read data
  always_comb begin
    cfg_d   = cfg_q;
    flag_d  = flag_q;
    stat_d  = stat_q;
    ien_d   = ien_q;
    rdata_d = `DEIC_RD_UNMAPPED;
    if (wr_stb && hit(addr, `DEIC_CTRL_OFFSET)) begin
      cfg_d = wdata[6:0]; // flag bit ignored on write
    end
    if (wr_stb && hit(addr, `DEIC_IEN_OFFSET)) begin
      ien_d = wdata[0];
    end
    if (wr_stb && hit(addr, `DEIC_CLR_OFFSET) && wdata[0]) begin
      stat_d = 1'b0;
    end
    if (rd_stb) begin
      if (hit(addr, `DEIC_CTRL_OFFSET)) begin
        rdata_d = {24'h00_0000, flag_q, cfg_q};
        flag_d  = 1'b0; // read clears
      end else if (hit(addr, `DEIC_STAT_OFFSET)) begin
        rdata_d = {31'h0000_0000, stat_q};
      end else if (hit(addr, `DEIC_IEN_OFFSET)) begin
        rdata_d = {31'h0000_0000, ien_q};
      end
    end
    if (sel.edge_hit) begin
      flag_d = 1'b1; // set beats the clearing read
    end
    // status latches each rise of the flag while enabled
    if (sel.edge_hit && !flag_q && cfg_q[`DEIC_MASK_BIT]) begin
      stat_d = 1'b1;
    end
    irq_d = stat_d & ien_d;
  end

  // registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q   <= `DEIC_CTRL_RESET;
      flag_q  <= 1'b0;
      stat_q  <= 1'b0;
      ien_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      irq_q   <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      flag_q  <= flag_d;
      stat_q  <= stat_d;
      ien_q   <= ien_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end

  assign rdata         = rdata_q;
  assign diag_irq_line = irq_q;

  // reference copy of the selected bit, built from the pins and not from the detector
  assign diag_all = {radio_diag_word1, radio_diag_word0, link_diag_word1, link_diag_word0};
  assign lane_ref = diag_all[{sel.source_word_sel, sel.bit_lane_sel}];

  // a detected edge always leaves the flag set
  chk_flag_sets_on_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sel.edge_hit |=> flag_q)
    else $error("edge did not set flag");

  // without an edge or a control read the flag keeps its value
  chk_flag_holds_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!sel.edge_hit && !(rd_stb && addr == `DEIC_CTRL_OFFSET)) |=> flag_q == $past(flag_q))
    else $error("flag changed with no cause");

  // a control read with no new edge clears the flag
  chk_read_clears_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rd_stb && addr == `DEIC_CTRL_OFFSET && !sel.edge_hit) |=> !flag_q)
    else $error("read did not clear flag");

  // writes never move the flag, not even a one written to its bit
  chk_write_keeps_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && !rd_stb && !sel.edge_hit) |=> flag_q == $past(flag_q))
    else $error("write changed flag");

  // an edge that meets a clearing read still leaves the flag set
  chk_edge_beats_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.edge_hit && rd_stb) |=> flag_q)
    else $error("edge lost on read");

  // rising polarity fires only from a low history
  chk_rise_edge_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!sel.edge_polarity_sel && sel.edge_hit) |-> !u_det.bit_q)
    else $error("rising edge mismatch");

  // falling polarity fires only from a high history
  chk_fall_edge_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.edge_polarity_sel && sel.edge_hit) |-> u_det.bit_q)
    else $error("falling edge mismatch");

  // a rising hit needs the pin bit high now
  chk_rise_needs_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!sel.edge_polarity_sel && sel.edge_hit) |-> lane_ref)
    else $error("rising hit with pin low");

  // a falling hit needs the pin bit low now
  chk_fall_needs_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.edge_polarity_sel && sel.edge_hit) |-> !lane_ref)
    else $error("falling hit with pin high");

  // with a steady selection, every change towards the chosen level is a hit
  chk_edge_from_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(rst_n) && $stable(cfg_q) && (lane_ref != $past(lane_ref))
     && (lane_ref != sel.edge_polarity_sel)) |-> sel.edge_hit)
    else $error("pin edge not detected");

  // the monitored bit is the lane of the chosen word at the pins
  chk_lane_index: assert property (@(posedge ref_clk) disable iff (!rst_n)
    u_det.bit_now == lane_ref)
    else $error("lane mismatch");

  // word code 00 picks link word 0
  chk_word_link0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.source_word_sel == DEIC_SRC_LINK0) |-> u_det.word_sel == link_diag_word0)
    else $error("word select mismatch");

  // word code 01 picks link word 1
  chk_word_link1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.source_word_sel == DEIC_SRC_LINK1) |-> u_det.word_sel == link_diag_word1)
    else $error("word select mismatch");

  // word code 10 picks radio word 0
  chk_word_radio0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.source_word_sel == DEIC_SRC_RADIO0) |-> u_det.word_sel == radio_diag_word0)
    else $error("word select mismatch");

  // word code 11 picks radio word 1
  chk_word_radio1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.source_word_sel == DEIC_SRC_RADIO1) |-> u_det.word_sel == radio_diag_word1)
    else $error("word select mismatch");

  // a rise of the flag while enabled raises the line
  chk_irq_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel.edge_hit && !flag_q && cfg_q[0] && ien_q) |-> ##[1:2] diag_irq_line)
    else $error("irq missing");

  // status stays clear while the channel is masked
  chk_no_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!stat_q && (!cfg_q[0] || !sel.edge_hit)) |=> !stat_q)
    else $error("status set while masked");

  // the line stays low while the interrupt enable is off
  chk_irq_needs_ien: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!ien_q && !wr_stb) |=> !diag_irq_line)
    else $error("irq with enable off");

  // the line stays low while no status is pending
  chk_irq_needs_stat: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!stat_q && !sel.edge_hit) |=> !diag_irq_line)
    else $error("irq with no status");

  // a clear write with no new edge drops the status
  chk_stat_clear_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_stb && addr == `DEIC_CLR_OFFSET && wdata[0] && !sel.edge_hit) |=> !stat_q)
    else $error("status not cleared");

  // read data stand only in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_stb |=> rdata == `DEIC_RD_UNMAPPED)
    else $error("read data outside read cycle");

  // main scenarios: any edge, interrupt rise, edge racing a read, masked and falling edges
  cov_edge_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) sel.edge_hit);
  cov_irq_up: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(diag_irq_line));
  cov_read_edge: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sel.edge_hit && rd_stb && addr == `DEIC_CTRL_OFFSET);
  cov_masked_edge: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sel.edge_hit && !cfg_q[`DEIC_MASK_BIT]);
  cov_fall_edge: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sel.edge_hit && sel.edge_polarity_sel);
endmodule // deic_channel

//--- verif/deic_diag_src.sv
// behavioural model of the four diagnostic word sources
`timescale 1ns/10ps
module deic_diag_src
  import deic_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       set_en,
  input  wire logic [1:0] set_src,
  input  wire logic [2:0] set_lane,
  input  wire logic       set_val,
  output deic_diag_t      words_q [4]
);
  // all words start low; one bit of one word changes per command
  initial words_q = '{default: 8'h00};
  always @(posedge ref_clk) begin
    if (set_en) begin
      words_q[set_src][set_lane] <= set_val;
    end
  end
endmodule // deic_diag_src

//--- verif/deic_channel_bench.sv
// self-checking bench for the diagnostic edge interrupt channel
`timescale 1ns/10ps
`include "deic_consts.svh"
module deic_channel_bench
  import deic_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic       set_en  = 1'b0;
  logic       set_val = 1'b0;
  logic [1:0] set_src = 2'h0;
  logic [2:0] set_lane = 3'h0;
  deic_word_t addr    = 32'h0000_0000;
  deic_word_t wdata   = 32'h0000_0000;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [7:0] cfg;
  logic       diag_irq_line;
  deic_diag_t words [4];
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         i;

  deic_diag_src deic_diag_src_inst (.ref_clk(ref_clk), .set_en(set_en), .set_src(set_src),
    .set_lane(set_lane), .set_val(set_val), .words_q(words));
  deic_channel deic_channel_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .link_diag_word0(words[0]), .link_diag_word1(words[1]), .radio_diag_word0(words[2]),
    .radio_diag_word1(words[3]), .diag_irq_line(diag_irq_line));

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one register access; read data taken in the cycle after the strobe
  task automatic acc(input logic we, input deic_word_t a, input deic_word_t d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= we;
    rd_stb <= ~we;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask

  // ask the source model to move one bit, then let the edge settle
  task automatic put(input logic [1:0] s, input logic [2:0] l, input logic b);
    @(posedge ref_clk);
    set_src <= s;
    set_lane <= l;
    set_val <= b;
    set_en <= 1'b1;
    @(posedge ref_clk);
    set_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end

  // every word, lane and polarity in turn, then masked, racing and disabled cases
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    acc(1'b1, `DEIC_IEN_OFFSET, 32'h0000_0001);
    acc(1'b0, `DEIC_IEN_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0001);
    for (i = 0; i < 8; i++) begin
      cfg = {1'b0, i[2], i[2:0], i[1:0], 1'b1};
      acc(1'b1, `DEIC_CTRL_OFFSET, {24'h00_0000, 1'b1, cfg[6:0]});
      acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
      put(i[1:0], i[2:0], i[2]);
      put(2'(i + 1), i[2:0], ~i[2]);
      acc(1'b1, `DEIC_CLR_OFFSET, 32'h0000_0001);
      acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
      chk(v, {24'h00_0000, cfg});
      chk(32'(diag_irq_line), 32'h0000_0000);
      put(i[1:0], i[2:0], ~i[2]);
      chk(32'(diag_irq_line), 32'h0000_0001);
      acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
      chk(v, {24'h00_0000, 1'b1, cfg[6:0]});
      acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
      chk(v, {24'h00_0000, cfg});
      acc(1'b0, `DEIC_STAT_OFFSET, 32'h0000_0000);
      chk(v, 32'h0000_0001);
      acc(1'b1, `DEIC_CLR_OFFSET, 32'h0000_0001);
      acc(1'b0, `DEIC_STAT_OFFSET, 32'h0000_0000);
      chk(v, 32'h0000_0000);
      chk(32'(diag_irq_line), 32'h0000_0000);
    end
    acc(1'b1, `DEIC_CTRL_OFFSET, 32'h0000_0000);
    put(2'h0, 3'h0, 1'b0);
    acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
    put(2'h0, 3'h0, 1'b1);
    chk(32'(diag_irq_line), 32'h0000_0000);
    acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0080);
    acc(1'b0, `DEIC_STAT_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    // edge seen by the design at the very edge that samples a control read
    put(2'h0, 3'h0, 1'b0);
    fork
      put(2'h0, 3'h0, 1'b1);
      begin
        @(posedge ref_clk);
        acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
      end
    join
    chk(v, 32'h0000_0000);
    acc(1'b0, `DEIC_CTRL_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0080);
    // channel unmasked but interrupt enable off: status only, then line on enable
    acc(1'b1, `DEIC_IEN_OFFSET, 32'h0000_0000);
    acc(1'b1, `DEIC_CTRL_OFFSET, 32'h0000_0001);
    put(2'h0, 3'h0, 1'b0);
    put(2'h0, 3'h0, 1'b1);
    chk(32'(diag_irq_line), 32'h0000_0000);
    acc(1'b0, `DEIC_STAT_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0001);
    acc(1'b0, `DEIC_IEN_OFFSET, 32'h0000_0000);
    chk(v, 32'h0000_0000);
    acc(1'b1, `DEIC_IEN_OFFSET, 32'h0000_0001);
    chk(32'(diag_irq_line), 32'h0000_0001);
    acc(1'b0, 32'h4000_0300, 32'h0000_0000);
    chk(v, `DEIC_RD_UNMAPPED);
    give_verdict();
  end
endmodule // deic_channel_bench
